/* File: hdl/scl_pkg.sv */
// constants and types shared by the synchronism check logic
package scl_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_VWIN   = 8'h04;
	localparam logic [7:0] ADDR_SLIP   = 8'h08;
	localparam logic [7:0] ADDR_ANGLE  = 8'h0C;
	localparam logic [7:0] ADDR_CLOSE  = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_SLIPV  = 8'h18;
	localparam logic [7:0] ADDR_ANGV   = 8'h1C;
	localparam logic [7:0] ADDR_ISTAT  = 8'h20;
	localparam logic [7:0] ADDR_IMASK  = 8'h24;
	// field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_SRC_LSB  = 1;
	localparam int CTRL_OFF_BIT  = 4;
	localparam int VWIN_HI_LSB   = 16;
	localparam int ANG2_LSB      = 16;
	// phase source codes
	localparam logic [2:0] SRC_A  = 3'h0;
	localparam logic [2:0] SRC_B  = 3'h1;
	localparam logic [2:0] SRC_C  = 3'h2;
	localparam logic [2:0] SRC_AB = 3'h3;
	localparam logic [2:0] SRC_BC = 3'h4;
	localparam logic [2:0] SRC_CA = 3'h5;
	// reset values: volts in 0.01 V, slip in mHz, angles in 0.1 deg, close time in 0.01 cycle
	localparam logic [15:0] RST_VLO    = 16'h1770;
	localparam logic [15:0] RST_VHI    = 16'h2710;
	localparam logic [8:0]  RST_SLIP   = 9'h064;
	localparam logic [9:0]  RST_ANG    = 10'h0FA;
	localparam logic [12:0] RST_TCLOSE = 13'h03E8;
	localparam logic [2:0]  RST_SRC    = 3'h0;
	localparam logic        RST_OFF    = 1'h1;
	// arithmetic constants
	localparam logic [14:0] SQRT3_Q14  = 15'h6EDA;
	localparam int          SQRT3_SH   = 14;
	localparam logic [20:0] SLIP_STATIC = 21'h000005;
	localparam logic signed [47:0] COMP_NUM = 48'sh000000000E10;
	localparam logic signed [47:0] COMP_DEN = 48'sh0000005B8D80;
	localparam logic signed [15:0] DEG_180 = 16'sh0708;
	localparam logic signed [15:0] DEG_360 = 16'sh0E10;
	localparam logic [10:0] ZERO_TOL   = 11'h002;
	// evaluation sequence
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_QUAL = 4'b0010,
		ST_SLIP = 4'b0100,
		ST_ELEM = 4'b1000
	} scl_state_t;
endpackage

/* File: hdl/scl_calc_if.sv */
// bundle between the sequencer and the angle difference calculator
`timescale 1ns/1ns
interface scl_calc_if;
	logic signed [20:0] slip;
	logic        [12:0] close_time;
	logic               close_off;
	logic signed [11:0] ang_p;
	logic signed [11:0] ang_s;
	logic               comp_en;
	logic        [10:0] angle;
	modport req  (output slip, close_time, close_off, ang_p, ang_s, input comp_en, angle);
	modport calc (input slip, close_time, close_off, ang_p, ang_s, output comp_en, angle);
endinterface

/* File: hdl/scl_angle_calc.sv */
// angle difference with breaker close time compensation, wrapped to 0..180 deg
`timescale 1ns/1ns
module scl_angle_calc (
	scl_calc_if.calc c
);
	logic        [20:0] abs_slip;
	logic signed [47:0] comp_w;
	logic signed [15:0] comp;
	logic signed [15:0] sum;
	logic signed [15:0] w;

	// magnitude of slip decides static versus slipping
	always_comb begin
		abs_slip  = c.slip[20] ? 21'(-c.slip) : c.slip;
		c.comp_en = (abs_slip > scl_pkg::SLIP_STATIC) && !c.close_off;
	end

	// slip * close time * 360 / 60, in 0.1 deg; integer division truncates toward zero
	always_comb begin
		comp_w = (48'(c.slip) * 48'(signed'({1'b0, c.close_time})) * scl_pkg::COMP_NUM)
			/ scl_pkg::COMP_DEN;
		// whole turns of compensation change nothing; dropping them keeps the sum foldable
		comp_w = comp_w % 48'(scl_pkg::DEG_360);
		comp   = c.comp_en ? comp_w[15:0] : 16'sh0000;
		sum    = 16'(c.ang_p) - 16'(c.ang_s) + comp;
		// two folds cover the worst case of raw plus full compensation
		w = sum;
		if (w > scl_pkg::DEG_180) begin
			w = w - scl_pkg::DEG_360;
		end
		if (w > scl_pkg::DEG_180) begin
			w = w - scl_pkg::DEG_360;
		end
		if (w < -scl_pkg::DEG_180) begin
			w = w + scl_pkg::DEG_360;
		end
		if (w < -scl_pkg::DEG_180) begin
			w = w + scl_pkg::DEG_360;
		end
		c.angle = w[15] ? 11'(-w) : w[10:0];
	end
endmodule

/* File: hdl/scl_top.sv */
// synchronism check front end: voltage window, slip, angle and element flags
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module scl_top (
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_in,
	input  wire logic [7:0]              paddr_in,
	input  wire logic                    psel_in,
	input  wire logic                    penable_in,
	input  wire logic                    pwrite_in,
	input  wire logic [31:0]             pwdata_in,
	output logic      [31:0]             prdata_out,
	output logic                         pready_out,
	output logic                         pslverr_out,
	input  wire logic [6:0][15:0]        mag_in,
	input  wire logic [6:0][11:0]        ang_in,
	input  wire logic [19:0]             freq_a_in,
	input  wire logic [19:0]             freq_s_in,
	input  wire logic                    eval_strobe_in,
	input  wire logic                    sync_block_condition_in,
	output logic                         phase_volt_healthy_out,
	output logic                         sync_volt_healthy_out,
	output logic                         phase_a_volt_healthy_out,
	output logic                         slip_ok_flag_out,
	output logic                         sync_ok_first_out,
	output logic                         sync_ok_second_out,
	output logic                         irq_out
);
	typedef struct packed {
		scl_pkg::scl_state_t st;
		logic               en;
		logic [2:0]         src;
		logic               cls_off;
		logic [15:0]        v_lo;
		logic [15:0]        v_hi;
		logic [8:0]         slip_max;
		logic [9:0]         ang1;
		logic [9:0]         ang2;
		logic [12:0]        tclose;
		logic               hp;
		logic               hs;
		logic               ha;
		logic               slip_ok;
		logic               ok1;
		logic               ok2;
		logic               dec;
		logic               have_prev;
		logic signed [20:0] slip;
		logic signed [11:0] angp;
		logic signed [11:0] angs;
		logic [10:0]        angle;
		logic [3:0]         ist;
		logic [3:0]         imask;
		logic [31:0]        rdata;
		logic               err;
	} scl_regs_t;

	scl_regs_t          r_q;
	scl_regs_t          r_d;
	scl_calc_if         calc ();
	logic [15:0]        sel_mag;
	logic signed [11:0] sel_ang;
	logic [16:0]        va_eff;
	logic               line_sel;
	logic               win_p;
	logic               win_s;
	logic               win_a;
	logic               gate;
	logic signed [20:0] fdiff;
	logic [20:0]        abs_slip;
	logic               dec_now;
	logic               zero_hit;
	logic               setup;
	logic               wr_en;
	logic [3:0]         ev;

	// inclusive window test shared by all three voltages
	function automatic logic in_window(input logic [16:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_window = (v >= {1'b0, lo}) && (v <= {1'b0, hi});
	endfunction

	function automatic logic [20:0] abs21(input logic signed [20:0] x);
		abs21 = x[20] ? 21'(-x) : x;
	endfunction

	// source selection and root-three scaling of phase A
	always_comb begin
		sel_mag  = mag_in[0];
		sel_ang  = ang_in[0];
		if (r_q.src == scl_pkg::SRC_B) begin
			sel_mag = mag_in[1];
			sel_ang = ang_in[1];
		end else if (r_q.src == scl_pkg::SRC_C) begin
			sel_mag = mag_in[2];
			sel_ang = ang_in[2];
		end else if (r_q.src == scl_pkg::SRC_AB) begin
			sel_mag = mag_in[3];
			sel_ang = ang_in[3];
		end else if (r_q.src == scl_pkg::SRC_BC) begin
			sel_mag = mag_in[4];
			sel_ang = ang_in[4];
		end else if (r_q.src == scl_pkg::SRC_CA) begin
			sel_mag = mag_in[5];
			sel_ang = ang_in[5];
		end
		line_sel = (r_q.src >= scl_pkg::SRC_AB) && (r_q.src <= scl_pkg::SRC_CA);
		// 17 bits keep the scaled value from wrapping near full scale
		va_eff = line_sel ? 17'((32'(mag_in[0]) * 32'(scl_pkg::SQRT3_Q14))
			>> scl_pkg::SQRT3_SH) : {1'b0, mag_in[0]};
		win_p  = in_window({1'b0, sel_mag}, r_q.v_lo, r_q.v_hi);
		win_s  = in_window({1'b0, mag_in[6]}, r_q.v_lo, r_q.v_hi);
		win_a  = in_window(va_eff, r_q.v_lo, r_q.v_hi);
		gate   = r_q.hp && r_q.hs && r_q.ha && !sync_block_condition_in;
		fdiff  = 21'(signed'({1'b0, freq_a_in})) - 21'(signed'({1'b0, freq_s_in}));
		abs_slip = abs21(r_q.slip);
	end

	// compensated angle comes from the calculator on the latched slip and angles
	assign calc.slip       = r_q.slip;
	assign calc.close_time = r_q.tclose;
	assign calc.close_off  = r_q.cls_off;
	assign calc.ang_p      = r_q.angp;
	assign calc.ang_s      = r_q.angs;

	scl_angle_calc u_calc (
		.c (calc.calc)
	);

	// trend of the compensated angle decides the zero-crossing test
	always_comb begin
		dec_now  = r_q.have_prev && (calc.angle < r_q.angle);
		zero_hit = dec_now && (calc.angle <= scl_pkg::ZERO_TOL);
	end

	// APB: read data and error are latched in setup, write lands in the access phase
	always_comb begin
		setup = psel_in && !penable_in;
		wr_en = psel_in && penable_in && pwrite_in && !r_q.err;
	end

	// sequencer, register file and interrupt status
	always_comb begin
		r_d = r_q;
		ev  = 4'h0;
		if (setup) begin
			r_d.err   = 1'b0;
			r_d.rdata = 32'h00000000;
			if (paddr_in == scl_pkg::ADDR_CTRL) begin
				r_d.rdata[scl_pkg::CTRL_EN_BIT]                       = r_q.en;
				r_d.rdata[scl_pkg::CTRL_SRC_LSB +: 3]                 = r_q.src;
				r_d.rdata[scl_pkg::CTRL_OFF_BIT]                      = r_q.cls_off;
			end else if (paddr_in == scl_pkg::ADDR_VWIN) begin
				r_d.rdata = {r_q.v_hi, r_q.v_lo};
			end else if (paddr_in == scl_pkg::ADDR_SLIP) begin
				r_d.rdata[8:0] = r_q.slip_max;
			end else if (paddr_in == scl_pkg::ADDR_ANGLE) begin
				r_d.rdata[9:0]                       = r_q.ang1;
				r_d.rdata[scl_pkg::ANG2_LSB +: 10]   = r_q.ang2;
			end else if (paddr_in == scl_pkg::ADDR_CLOSE) begin
				r_d.rdata[12:0] = r_q.tclose;
			end else if (paddr_in == scl_pkg::ADDR_STATUS) begin
				r_d.rdata[5:0] = {r_q.ok2, r_q.ok1, r_q.slip_ok, r_q.ha, r_q.hs, r_q.hp};
			end else if (paddr_in == scl_pkg::ADDR_SLIPV) begin
				r_d.rdata = 32'(r_q.slip);
			end else if (paddr_in == scl_pkg::ADDR_ANGV) begin
				r_d.rdata[10:0] = r_q.angle;
			end else if (paddr_in == scl_pkg::ADDR_ISTAT) begin
				r_d.rdata[3:0] = r_q.ist;
			end else if (paddr_in == scl_pkg::ADDR_IMASK) begin
				r_d.rdata[3:0] = r_q.imask;
			end else begin
				r_d.err = 1'b1;
			end
		end
		if (wr_en) begin
			if (paddr_in == scl_pkg::ADDR_CTRL) begin
				r_d.en      = pwdata_in[scl_pkg::CTRL_EN_BIT];
				r_d.src     = pwdata_in[scl_pkg::CTRL_SRC_LSB +: 3];
				r_d.cls_off = pwdata_in[scl_pkg::CTRL_OFF_BIT];
			end else if (paddr_in == scl_pkg::ADDR_VWIN) begin
				r_d.v_lo = pwdata_in[15:0];
				r_d.v_hi = pwdata_in[scl_pkg::VWIN_HI_LSB +: 16];
			end else if (paddr_in == scl_pkg::ADDR_SLIP) begin
				r_d.slip_max = pwdata_in[8:0];
			end else if (paddr_in == scl_pkg::ADDR_ANGLE) begin
				r_d.ang1 = pwdata_in[9:0];
				r_d.ang2 = pwdata_in[scl_pkg::ANG2_LSB +: 10];
			end else if (paddr_in == scl_pkg::ADDR_CLOSE) begin
				r_d.tclose = pwdata_in[12:0];
			end else if (paddr_in == scl_pkg::ADDR_IMASK) begin
				r_d.imask = pwdata_in[3:0];
			end
		end
		case (r_q.st)
			scl_pkg::ST_IDLE: begin
				if (eval_strobe_in && r_q.en) begin
					r_d.st = scl_pkg::ST_QUAL;
				end
			end
			scl_pkg::ST_QUAL: begin
				r_d.hp = win_p;
				r_d.hs = win_s;
				r_d.ha = win_a;
				r_d.st = scl_pkg::ST_SLIP;
			end
			scl_pkg::ST_SLIP: begin
				// angles are taken together with the slip so the pair is coherent
				if (gate) begin
					r_d.slip    = fdiff;
					r_d.slip_ok = abs21(fdiff) < 21'(r_q.slip_max);
					r_d.angp    = sel_ang;
					r_d.angs    = ang_in[6];
				end else begin
					r_d.slip_ok = 1'b0;
				end
				r_d.st = scl_pkg::ST_ELEM;
			end
			scl_pkg::ST_ELEM: begin
				if (r_q.slip_ok) begin
					r_d.angle     = calc.angle;
					r_d.have_prev = 1'b1;
					r_d.dec       = dec_now;
					if (!calc.comp_en) begin
						r_d.ok1 = calc.angle < 11'(r_q.ang1);
						r_d.ok2 = calc.angle < 11'(r_q.ang2);
					end else begin
						// past zero and opening again still passes below the limit
						r_d.ok1 = zero_hit || (!dec_now && calc.angle < 11'(r_q.ang1));
						r_d.ok2 = zero_hit || (!dec_now && calc.angle < 11'(r_q.ang2));
					end
				end else begin
					r_d.ok1       = 1'b0;
					r_d.ok2       = 1'b0;
					r_d.have_prev = 1'b0;
				end
				r_d.st = scl_pkg::ST_IDLE;
			end
			default: begin
				r_d.st = scl_pkg::ST_IDLE;
			end
		endcase
		// disabling drops the healthy, slip and element flags and have_prev at once; dec is left alone, and a dropped healthy flag sets interrupt status bit 3
		if (!r_d.en) begin
			r_d.st        = scl_pkg::ST_IDLE;
			r_d.hp        = 1'b0;
			r_d.hs        = 1'b0;
			r_d.ha        = 1'b0;
			r_d.slip_ok   = 1'b0;
			r_d.ok1       = 1'b0;
			r_d.ok2       = 1'b0;
			r_d.have_prev = 1'b0;
		end
		ev[0] = r_d.slip_ok && !r_q.slip_ok;
		ev[1] = r_d.ok1 && !r_q.ok1;
		ev[2] = r_d.ok2 && !r_q.ok2;
		ev[3] = (r_q.hp && !r_d.hp) || (r_q.hs && !r_d.hs) || (r_q.ha && !r_d.ha);
		// set wins over a write-one-to-clear in the same cycle
		r_d.ist = r_q.ist;
		if (wr_en && paddr_in == scl_pkg::ADDR_ISTAT) begin
			r_d.ist = r_q.ist & ~pwdata_in[3:0];
		end
		r_d.ist = r_d.ist | ev;
	end

	// single state register
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			r_q          <= '0;
			r_q.st       <= scl_pkg::ST_IDLE;
			r_q.src      <= scl_pkg::RST_SRC;
			r_q.cls_off  <= scl_pkg::RST_OFF;
			r_q.v_lo     <= scl_pkg::RST_VLO;
			r_q.v_hi     <= scl_pkg::RST_VHI;
			r_q.slip_max <= scl_pkg::RST_SLIP;
			r_q.ang1     <= scl_pkg::RST_ANG;
			r_q.ang2     <= scl_pkg::RST_ANG;
			r_q.tclose   <= scl_pkg::RST_TCLOSE;
		end else begin
			r_q <= r_d;
		end
	end

	// outputs straight from the state register, except pready tied high, pslverr gated by psel and penable, and irq from the masked interrupt status
	assign prdata_out               = r_q.rdata;
	assign pready_out               = 1'b1;
	assign pslverr_out              = psel_in && penable_in && r_q.err;
	assign phase_volt_healthy_out   = r_q.hp;
	assign sync_volt_healthy_out    = r_q.hs;
	assign phase_a_volt_healthy_out = r_q.ha;
	assign slip_ok_flag_out         = r_q.slip_ok;
	assign sync_ok_first_out        = r_q.ok1;
	assign sync_ok_second_out       = r_q.ok2;
	assign irq_out                  = |(r_q.ist & r_q.imask);

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	win_phase_a: assert property (r_q.st == scl_pkg::ST_QUAL && r_d.en |=>
		r_q.hp == $past(win_p)) else $error("phase healthy flag wrong");
	win_sync_a: assert property (r_q.st == scl_pkg::ST_QUAL && r_d.en |=>
		r_q.hs == $past(win_s)) else $error("sync healthy flag wrong");
	src_pick_a: assert property (r_q.src == scl_pkg::SRC_CA |->
		sel_mag == mag_in[5] && sel_ang == ang_in[5]) else $error("source select wrong");
	win_phasea_a: assert property (r_q.st == scl_pkg::ST_QUAL && r_d.en |=>
		r_q.ha == $past(win_a)) else $error("phase A healthy flag wrong");
	scale_line_a: assert property (line_sel |->
		va_eff >= 17'(mag_in[0]) + 17'(mag_in[0] >> 1) && va_eff <= {mag_in[0], 1'b0})
		else $error("line voltage not scaled");
	slip_gate_a: assert property (r_q.st == scl_pkg::ST_SLIP && !gate |=>
		!r_q.slip_ok && $stable(r_q.slip)) else $error("slip ran while blocked");
	slip_sign_a: assert property (r_q.st == scl_pkg::ST_SLIP && gate && r_d.en |=>
		r_q.slip == $past(fdiff)) else $error("slip value wrong");
	slip_cmp_a: assert property (r_q.slip_ok |->
		abs_slip < 21'(r_q.slip_max)) else $error("slip flag above limit");
	angle_gate_a: assert property (r_q.st == scl_pkg::ST_ELEM && !r_q.slip_ok |=>
		!r_q.ok1 && !r_q.ok2 && $stable(r_q.angle)) else $error("angle ran without slip");
	comp_sel_a: assert property (calc.comp_en ==
		(abs_slip > scl_pkg::SLIP_STATIC && !r_q.cls_off)) else $error("compensation select wrong");
	static_elem_a: assert property (r_q.st == scl_pkg::ST_ELEM && r_q.slip_ok
		&& !calc.comp_en && r_d.en |=> r_q.ok2 == (r_q.angle < 11'(r_q.ang2)))
		else $error("static element wrong");
	zero_hit_a: assert property (r_q.st == scl_pkg::ST_ELEM && r_q.slip_ok && calc.comp_en
		&& zero_hit && r_d.en |=> r_q.ok1 && r_q.ok2) else $error("zero crossing missed");
	disable_clr_a: assert property (!r_q.en |-> !r_q.hp && !r_q.slip_ok &&
		!r_q.ok1 && !r_q.ok2) else $error("flags set while disabled");
	angle_wrap_a: assert property (calc.angle <= 11'(scl_pkg::DEG_180))
		else $error("angle out of 0..180");
endmodule

/* File: tb/scl_top_tb_top.sv */
// self-checking bench for the synchronism check front end
`timescale 1ns/1ns
module scl_top_tb_top;
	logic             sys_clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out;
	logic             pslverr_out, eval_strobe_in, sync_block_condition_in, irq_out;
	logic             phase_volt_healthy_out, sync_volt_healthy_out, phase_a_volt_healthy_out;
	logic             slip_ok_flag_out, sync_ok_first_out, sync_ok_second_out, err_q;
	logic [7:0]       paddr_in;
	logic [31:0]      pwdata_in, prdata_out, rd_q;
	logic [6:0][15:0] mag_in;
	logic [6:0][11:0] ang_in;
	logic [19:0]      freq_a_in, freq_s_in;
	logic [5:0]       flags;
	int               err_count, comparisons, cycles;

	scl_top i_scl_top (.sys_clk_in, .rst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .mag_in, .ang_in, .freq_a_in,
		.freq_s_in, .eval_strobe_in, .sync_block_condition_in, .phase_volt_healthy_out,
		.sync_volt_healthy_out, .phase_a_volt_healthy_out, .slip_ok_flag_out,
		.sync_ok_first_out, .sync_ok_second_out, .irq_out);

	// flags gathered in status register order
	assign flags = {sync_ok_second_out, sync_ok_first_out, slip_ok_flag_out,
		phase_a_volt_healthy_out, sync_volt_healthy_out, phase_volt_healthy_out};

	// 125 MHz clock
	initial sys_clk_in = 1'b0;
	always #4 sys_clk_in = ~sys_clk_in;

	task automatic summarize();
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; idle edge afterwards so the next setup never collides with release
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		paddr_in <= a;
		pwrite_in <= w;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		@(posedge sys_clk_in);
		// only the bench timeout ends a wait that never sees pready
		while (pready_out !== 1'b1) begin
			@(posedge sys_clk_in);
		end
		rd_q = prdata_out;
		err_q = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h00000000);
		chk_word(rd_q, exp, "read data");
	endtask

	// one strobe, then wait past the element update at strobe +3
	task automatic evaluate();
		eval_strobe_in <= 1'b1;
		@(posedge sys_clk_in);
		eval_strobe_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
	endtask

	task automatic t_regs();
		rd(scl_pkg::ADDR_CTRL, 32'h00000010);
		rd(scl_pkg::ADDR_VWIN, 32'h27101770);
		rd(scl_pkg::ADDR_SLIP, 32'h00000064);
		rd(scl_pkg::ADDR_ANGLE, 32'h00FA00FA);
		rd(scl_pkg::ADDR_CLOSE, 32'h000003E8);
		wr(scl_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		rd(scl_pkg::ADDR_STATUS, 32'h00000000);
		apb(8'h30, 1'b0, 32'h00000000);
		chk_word({31'h0, err_q}, 32'h00000001, "unmapped error flag");
	endtask

	// every source at the low edge, sync at the high edge; phase A at 40 V when it is not the source
	task automatic t_window();
		logic [6:0][15:0] m;
		for (int s = 0; s < 6; s++) begin
			wr(scl_pkg::ADDR_CTRL, 32'h00000011 | (32'(s) << 1));
			m = {7{16'h0FA0}};
			m[s] = 16'h1770;
			m[6] = 16'h2710;
			mag_in <= m;
			evaluate();
			chk_word({29'h0, flags[2:0]}, {29'h0, s == 0 || s >= 3, 2'b11}, "window");
		end
		// one step outside each edge
		wr(scl_pkg::ADDR_CTRL, 32'h00000011);
		m = {7{16'h1F40}};
		m[0] = 16'h2711;
		m[6] = 16'h176F;
		mag_in <= m;
		evaluate();
		chk_word({26'h0, flags}, 32'h00000000, "outside window");
		mag_in <= {7{16'h1F40}};
	endtask

	task automatic t_slip();
		logic [19:0] fs [3];
		logic        ok [3];
		logic [31:0] sv [3];
		fs = '{20'h0EA92, 20'h0E9FC, 20'h0E9FD};
		ok = '{1'b1, 1'b0, 1'b1};
		sv = '{32'hFFFFFFCE, 32'h00000000, 32'h00000063};
		for (int i = 0; i < 3; i++) begin
			freq_s_in <= fs[i];
			evaluate();
			chk_word({31'h0, slip_ok_flag_out}, {31'h0, ok[i]}, "slip ok");
			if (ok[i]) begin
				rd(scl_pkg::ADDR_SLIPV, sv[i]);
				rd(scl_pkg::ADDR_ANGV, 32'h00000000);
			end
		end
		sync_block_condition_in <= 1'b1;
		freq_s_in <= 20'h0EA92;
		evaluate();
		chk_word({26'h0, flags}, 32'h00000007, "blocked");
		sync_block_condition_in <= 1'b0;
	endtask

	task automatic ang_case(input logic [11:0] p, input logic [11:0] q,
			input logic [31:0] ea, input logic [1:0] ee);
		logic [6:0][11:0] a;
		a = '0;
		a[0] = p;
		a[6] = q;
		ang_in <= a;
		evaluate();
		rd(scl_pkg::ADDR_ANGV, ea);
		chk_word({30'h0, flags[5:4]}, {30'h0, ee}, "elements");
	endtask

	task automatic t_angle();
		freq_s_in <= 20'h0EA60;
		wr(scl_pkg::ADDR_ANGLE, 32'h009600FA);
		ang_case(12'h064, 12'hFCE, 32'h00000096, 2'b01);
		ang_case(12'h6A4, 12'h95C, 32'h000000C8, 2'b01);
		wr(scl_pkg::ADDR_CTRL, 32'h00000001);
		wr(scl_pkg::ADDR_SLIP, 32'h000000C8);
		wr(scl_pkg::ADDR_ANGLE, 32'h000000FA);
		freq_s_in <= 20'h0EA65;
		ang_case(12'h064, 12'h000, 32'h00000064, 2'b01);
		// blocked pass clears the trend history
		sync_block_condition_in <= 1'b1;
		evaluate();
		sync_block_condition_in <= 1'b0;
		freq_s_in <= 20'h0EAC4;
		ang_case(12'h064, 12'h000, 32'h00000028, 2'b01);
		ang_case(12'h03E, 12'h000, 32'h00000002, 2'b11);
	endtask

	task automatic t_irq();
		freq_s_in <= 20'h0EA60;
		sync_block_condition_in <= 1'b1;
		evaluate();
		sync_block_condition_in <= 1'b0;
		wr(scl_pkg::ADDR_ISTAT, 32'h0000000F);
		wr(scl_pkg::ADDR_IMASK, 32'h00000001);
		chk_word({31'h0, irq_out}, 32'h00000000, "irq idle");
		evaluate();
		chk_word({31'h0, irq_out}, 32'h00000001, "irq on slip ok rise");
		wr(scl_pkg::ADDR_IMASK, 32'h00000000);
		chk_word({31'h0, irq_out}, 32'h00000000, "irq masked");
		wr(scl_pkg::ADDR_IMASK, 32'h00000001);
		chk_word({31'h0, irq_out}, 32'h00000001, "irq sticky");
		wr(scl_pkg::ADDR_ISTAT, 32'h00000001);
		chk_word({31'h0, irq_out}, 32'h00000000, "irq cleared");
	endtask

	// disabling drops every flag and later strobes are ignored
	task automatic t_disable();
		wr(scl_pkg::ADDR_CTRL, 32'h00000000);
		chk_word({26'h0, flags}, 32'h00000000, "disabled");
		evaluate();
		chk_word({26'h0, flags}, 32'h00000000, "disabled strobe");
	endtask

	// cycle ceiling well above the few hundred cycles the tests need
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		rst_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h00;
		pwdata_in = 32'h00000000;
		eval_strobe_in = 1'b0;
		sync_block_condition_in = 1'b0;
		mag_in = {7{16'h1F40}};
		ang_in = '0;
		freq_a_in = 20'h0EA60;
		freq_s_in = 20'h0EA60;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		t_regs();
		t_window();
		t_slip();
		t_angle();
		t_irq();
		t_disable();
		summarize();
	end
endmodule
